// file: rtl/crch_pkg.sv
// Package of constants for the configuration reset command handler.
package crch_pkg;
    // ****************************************************************
    // Register map (byte addresses on APB)
    // ****************************************************************
    localparam logic [11:0] CV_WINDOW_BASE  = 12'h000;
    localparam logic [11:0] CTRL_ADDR       = 12'h800;
    localparam logic [11:0] STATUS_ADDR     = 12'h804;
    localparam logic [11:0] CMD_ADDR        = 12'h808;
    localparam logic [11:0] LAST_SET_ADDR   = 12'h80C;
    localparam logic [11:0] FW_REQ_ADDR     = 12'h810;
    localparam logic [11:0] DEFAULT_ADDR    = 12'h814;
    localparam int          CV_COUNT        = 256;
    localparam int          CV_ADDR_BITS    = 8;
    // ****************************************************************
    // Special variable numbers and values
    // ****************************************************************
    localparam logic [7:0]  IDENT_AND_RESET_VARIABLE      = 8'h08;
    localparam logic [7:0]  UPDATE_LOCK_VARIABLE          = 8'h90;
    localparam logic [7:0]  GEAR_BACKLASH_VARIABLE        = 8'h92;
    localparam logic [7:0]  TOP_SPEED_REGULATION_VARIABLE = 8'h96;
    localparam logic [7:0]  UPDATE_LOCK_VALUE             = 8'h80;
    localparam logic [7:0]  SET_GEAR_BACKLASH_DEFAULT     = 8'h1E;
    localparam logic [7:0]  SET_TOP_SPEED_DEFAULT         = 8'hFF;
    localparam logic [7:0]  RESET_CMD_FACTORY             = 8'h00;
    localparam logic [7:0]  RESET_CMD_REPEAT              = 8'h08;
    localparam logic [7:0]  FACTORY_DEFAULT_VALUE         = 8'h00;
    localparam logic [7:0]  SET_NONE                      = 8'h00;
    // Status and control bit positions.
    localparam int ST_BUSY    = 0;
    localparam int ST_LOCKED  = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_SOUND   = 3;
    localparam int CTRL_SOUND = 0;
    // ****************************************************************
    // Reset engine states
    // ****************************************************************
    typedef enum logic [1:0] {
        CRCH_IDLE  = 2'b00,
        CRCH_SWEEP = 2'b01
    } crch_state_type;
    typedef enum logic [1:0] {
        CRCH_SRC_FACTORY = 2'b00,
        CRCH_SRC_SET     = 2'b01,
        CRCH_SRC_SOUND   = 2'b10
    } crch_src_type;
endpackage

// file: rtl/crch_top.sv
// Configuration variable store with identification and hard reset command handling.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Variable 8 reads fixed identity code.
// R02: Writes to variable 8 act, never store.
// R03: Set number write: hard reset with set.
// R04: Value 8 repeats last set reset.
// R05: Sound variant restores sound project values for nonzero values.
// R06: Value 0 restores plain factory defaults.
// R07: Ordinary variable writes allowed after resets.
// R08: Bitwise variables: bit n weighs 2^n.
// R09: Variable 144 at 128 refuses firmware update.
// R10: Set defaults: 146=30, 150=255.
// R11: Last applied set number is retained.
module crch_top #(
    parameter logic [7:0] MAKER_ID = 8'h5A  // Arbitrary neutral identity value.
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             update_locked_o,
    output logic             fw_refused_o
);
    // ****************************************************************
    // Storage and state
    // ****************************************************************
    logic [7:0]                  cv_mem [crch_pkg::CV_COUNT];
    logic [7:0]                  sound_default [crch_pkg::CV_COUNT];
    crch_pkg::crch_state_type    state;
    crch_pkg::crch_src_type      src;
    logic [crch_pkg::CV_ADDR_BITS-1:0] sweep_idx;
    logic [7:0]                  last_set;
    logic                        sound_variant;
    logic                        refused;
    logic                        setup_ph;
    logic                        wr_cv;
    logic                        wr_cmd;
    logic [7:0]                  cmd_val;
    logic [7:0]                  wr_idx;
    logic [7:0]                  next_fill;
    logic                        sweeping;
    logic                        locked;
    logic                        sel_cv;
    logic                        sel_snd;
    logic                        sel_ctrl;
    logic                        sel_status;
    logic                        sel_cmd;
    logic                        sel_fw;
    logic                        setup_wr;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Variables and the sound table decode by region, so every word inside them answers.
    assign sel_cv     = (paddr_i[11:10] == 2'b00);
    assign sel_snd    = (paddr_i[11:10] == 2'b01);
    assign sel_ctrl   = (paddr_i == crch_pkg::CTRL_ADDR);
    assign sel_status = (paddr_i == crch_pkg::STATUS_ADDR);
    assign sel_cmd    = (paddr_i == crch_pkg::CMD_ADDR);
    assign sel_fw     = (paddr_i == crch_pkg::FW_REQ_ADDR);
    assign setup_wr   = setup_ph && pwrite_i;

    assign sweeping = (state == crch_pkg::CRCH_SWEEP);
    assign setup_ph = psel_i && !penable_i;
    assign wr_idx   = paddr_i[9:2];
    // Accepted in setup so the access phase always completes in one cycle.
    assign wr_cmd   = setup_ph && pwrite_i && !sweeping &&
                      ((paddr_i[11:10] == 2'b00 && wr_idx == crch_pkg::IDENT_AND_RESET_VARIABLE) ||
                       paddr_i == crch_pkg::CMD_ADDR); // R02
    assign wr_cv    = setup_ph && pwrite_i && !sweeping && paddr_i[11:10] == 2'b00 &&
                      wr_idx != crch_pkg::IDENT_AND_RESET_VARIABLE; // R07
    assign cmd_val  = pwdata_i[7:0];
    assign locked   = (cv_mem[crch_pkg::UPDATE_LOCK_VARIABLE] == crch_pkg::UPDATE_LOCK_VALUE); // R09

    // Value loaded into one variable during a hard reset sweep.
    always_comb begin
        next_fill = crch_pkg::FACTORY_DEFAULT_VALUE; // R06
        if (src == crch_pkg::CRCH_SRC_SOUND) begin
            next_fill = sound_default[sweep_idx]; // R05
        end else if (src == crch_pkg::CRCH_SRC_SET) begin
            // Only these three variables belong to the set here; the rest take the factory default.
            if (sweep_idx == crch_pkg::GEAR_BACKLASH_VARIABLE) begin
                next_fill = crch_pkg::SET_GEAR_BACKLASH_DEFAULT; // R10
            end else if (sweep_idx == crch_pkg::TOP_SPEED_REGULATION_VARIABLE) begin
                next_fill = crch_pkg::SET_TOP_SPEED_DEFAULT; // R10
            end else if (sweep_idx == crch_pkg::UPDATE_LOCK_VARIABLE) begin
                next_fill = crch_pkg::UPDATE_LOCK_VALUE;
            end
        end
    end

    // ****************************************************************
    // Command decode and sweep engine
    // ****************************************************************
    // Variable and command writes that arrive while a sweep runs are dropped but still answered, so software polls busy.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state     <= crch_pkg::CRCH_IDLE;
            src       <= crch_pkg::CRCH_SRC_FACTORY;
            sweep_idx <= '0;
            last_set  <= crch_pkg::SET_NONE;
        end else begin
            case (state)
                crch_pkg::CRCH_IDLE: begin
                    if (wr_cmd) begin
                        state     <= crch_pkg::CRCH_SWEEP;
                        sweep_idx <= '0;
                        if (cmd_val == crch_pkg::RESET_CMD_FACTORY) begin
                            src <= crch_pkg::CRCH_SRC_FACTORY; // R06
                        end else if (sound_variant) begin
                            src <= crch_pkg::CRCH_SRC_SOUND; // R05
                        end else if (cmd_val == crch_pkg::RESET_CMD_REPEAT) begin
                            // R04
                            src <= (last_set == crch_pkg::SET_NONE) ? crch_pkg::CRCH_SRC_FACTORY
                                                                    : crch_pkg::CRCH_SRC_SET;
                        end else begin
                            src      <= crch_pkg::CRCH_SRC_SET; // R03
                            last_set <= cmd_val; // R11
                        end
                    end
                end
                crch_pkg::CRCH_SWEEP: begin
                    // Every variable is visited, so no stale value from an earlier set survives.
                    sweep_idx <= sweep_idx + 8'h01;
                    if (sweep_idx == 8'hFF) begin
                        state <= crch_pkg::CRCH_IDLE;
                    end
                end
                default: begin
                    state <= crch_pkg::CRCH_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Variable storage, one generate entry per variable
    // ****************************************************************
    for (genvar i = 0; i < crch_pkg::CV_COUNT; i++) begin : g_cv
        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                cv_mem[i]        <= crch_pkg::FACTORY_DEFAULT_VALUE;
                sound_default[i] <= crch_pkg::FACTORY_DEFAULT_VALUE;
            end else begin
                if (sweeping && sweep_idx == 8'(i)) begin
                    cv_mem[i] <= next_fill;
                end else if (wr_cv && wr_idx == 8'(i)) begin
                    cv_mem[i] <= pwdata_i[7:0]; // R08
                end
                if (setup_wr && sel_snd && wr_idx == 8'(i)) begin
                    sound_default[i] <= pwdata_i[7:0];
                end
            end
        end
    end

    // ****************************************************************
    // Control, firmware gate and APB answer
    // ****************************************************************
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sound_variant <= 1'b0;
            refused       <= 1'b0;
        end else begin
            if (setup_wr && sel_ctrl) begin
                sound_variant <= pwdata_i[crch_pkg::CTRL_SOUND];
            end
            // A refusal caught in the same cycle as a clear wins over the clear.
            if (setup_wr && sel_fw && locked) begin
                refused <= 1'b1; // R09
            end else if (setup_wr && sel_status &&
                         pwdata_i[crch_pkg::ST_REFUSED]) begin
                refused <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o        <= 32'h0000_0000;
            pready_o        <= 1'b0;
            pslverr_o       <= 1'b0;
            update_locked_o <= 1'b0;
            fw_refused_o    <= 1'b0;
        end else begin
            update_locked_o <= locked;
            fw_refused_o    <= refused;
            pready_o        <= setup_ph;
            pslverr_o       <= 1'b0;
            prdata_o        <= 32'h0000_0000;
            if (setup_ph && !pwrite_i) begin
                if (paddr_i[11:10] == 2'b00) begin
                    if (wr_idx == crch_pkg::IDENT_AND_RESET_VARIABLE) begin
                        prdata_o <= {24'h000000, MAKER_ID}; // R01
                    end else begin
                        prdata_o <= {24'h000000, cv_mem[wr_idx]};
                    end
                end else if (paddr_i[11:10] == 2'b01) begin
                    prdata_o <= {24'h000000, sound_default[wr_idx]};
                end else if (paddr_i == crch_pkg::CTRL_ADDR) begin
                    prdata_o <= {31'h00000000, sound_variant};
                end else if (paddr_i == crch_pkg::STATUS_ADDR) begin
                    prdata_o <= {28'h0000000, sound_variant, refused, locked, sweeping};
                end else if (paddr_i == crch_pkg::LAST_SET_ADDR) begin
                    prdata_o <= {24'h000000, last_set}; // R11
                end else if (paddr_i != crch_pkg::CMD_ADDR && paddr_i != crch_pkg::FW_REQ_ADDR) begin
                    pslverr_o <= 1'b1;
                end
            end else if (setup_ph && pwrite_i) begin
                if (!(sel_cv || sel_snd || sel_ctrl || sel_status || sel_cmd || sel_fw)) begin
                    pslverr_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/crch_properties.sv
// Port checker for the configuration reset command handler.
`timescale 1ns/1ps
`default_nettype none
module crch_properties #(
    parameter logic [7:0] MAKER_ID = 8'h5A  // Arbitrary neutral identity value.
) (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        update_locked_o,
    input wire logic        fw_refused_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire logic setup = psel_i && !penable_i;
    wire logic fw_wr = setup && pwrite_i && paddr_i == crch_pkg::FW_REQ_ADDR;
    a_ready_after_setup: assert property (setup |=> pready_o)
        else $error("no ready after setup");
    a_ready_needs_setup: assert property (pready_o |-> $past(setup))
        else $error("ready without setup");
    a_ident_fixed: assert property (setup && !pwrite_i && paddr_i == 12'h020 |=> prdata_o == {24'h0, MAKER_ID})
        else $error("identity read wrong");
    a_byte_wide: assert property (pready_o && paddr_i < 12'h800 |-> prdata_o[31:8] == 24'h0)
        else $error("variable wider than a byte");
    a_unmapped_err: assert property (setup && paddr_i >= 12'h818 |=> pready_o && pslverr_o)
        else $error("unmapped access not flagged");
    a_lock_tracks: assert property (pready_o && !pwrite_i && paddr_i == 12'h240 && prdata_o == 32'h80
        |-> ##[0:1] update_locked_o)
        else $error("lock level missing");
    a_refuse_locked: assert property (fw_wr && update_locked_o |-> ##[1:2] fw_refused_o)
        else $error("update not refused");
    a_refused_sticky: assert property (fw_refused_o && !(psel_i && pwrite_i && paddr_i == crch_pkg::STATUS_ADDR)
        |=> fw_refused_o)
        else $error("refused flag dropped");
    cover property (setup && pwrite_i && paddr_i == crch_pkg::CMD_ADDR);
    cover property ($rose(fw_refused_o));
    cover property ($rose(update_locked_o));
endmodule
bind crch_top crch_properties #(.MAKER_ID(MAKER_ID)) u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .update_locked_o(update_locked_o),
    .fw_refused_o(fw_refused_o));
`default_nettype wire

// file: verif/crch_station.sv
// Command station model issuing variable accesses as an APB master.
`timescale 1ns/1ps
`default_nettype none
module crch_station (
    input  wire logic        sys_clk_i,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [11:0]      paddr_o,
    output logic [31:0]      pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h00000000;
    end
    // The answer is taken at the edge that samples pready high, before the slave's own update lands there.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic e, output logic ok);
        int n;
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= {24'h000000, d};
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        n = 0;
        ok = 1'b0;
        q = 32'h00000000;
        e = 1'b0;
        while (!ok && n < 20) begin
            @(posedge sys_clk_i);
            ok = (pready_i === 1'b1);
            q = prdata_i;
            e = pslverr_i;
            n++;
        end
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verif/crch_tb_top.sv
// Self-checking bench for the configuration reset command handler.
`timescale 1ns/1ps
`default_nettype none
module crch_tb_top;
    localparam logic [7:0] TB_ID = 8'hA7;  // Arbitrary identity value.
    logic        sys_clk_i;
    logic        reset_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        locked;
    logic        refused;
    int          num_errors = 0;
    int          comparisons = 0;
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    crch_top #(.MAKER_ID(TB_ID)) u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .update_locked_o(locked), .fw_refused_o(refused));
    crch_station u_station (.sys_clk_i(sys_clk_i), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    task automatic print_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        @(negedge sys_clk_i);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d,
                          output logic [31:0] q, output logic e);
        logic ok;
        u_station.xfer(wr, a, d, q, e, ok);
        if (!ok) begin
            num_errors++;
            $display("ERROR bus answer expected 1 seen 0");
            print_verdict();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        access(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        access(1'b0, a, 8'h00, q, e);
        chk(name, exp, q);
    endtask
    // A sweep takes some 256 cycles, so the poll bound leaves a wide margin.
    task automatic wait_idle();
        logic [31:0] q;
        logic        e;
        int          i;
        q = 32'h1;
        for (i = 0; i < 200 && q[crch_pkg::ST_BUSY] !== 1'b0; i++) access(1'b0, crch_pkg::STATUS_ADDR, 8'h00, q, e);
        chk("sweep busy", 32'h0, {31'h0, q[crch_pkg::ST_BUSY]});
        if (q[crch_pkg::ST_BUSY] !== 1'b0) begin
            print_verdict();
        end
    endtask
    function automatic logic [11:0] cv(input logic [7:0] n);
        return {2'b00, n, 2'b00};
    endfunction
    initial begin
        logic [31:0] q;
        logic        e;
        reset_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rd_chk("ident", cv(8'd8), {24'h0, TB_ID});
        wr(cv(8'd8), crch_pkg::RESET_CMD_FACTORY);
        wait_idle();
        rd_chk("ident kept", cv(8'd8), {24'h0, TB_ID});
        wr(cv(8'd20), 8'h35);
        wr(cv(8'd8), 8'h05);
        wr(cv(8'd20), 8'h77);
        wait_idle();
        rd_chk("backlash", cv(8'd146), 32'h1E);
        rd_chk("top speed", cv(8'd150), 32'hFF);
        rd_chk("lock var", cv(8'd144), 32'h80);
        rd_chk("plain var", cv(8'd20), 32'h0);
        rd_chk("last set", crch_pkg::LAST_SET_ADDR, 32'h5);
        chk("locked", 32'h1, {31'h0, locked});
        $display("set reset test done");
        wr(crch_pkg::FW_REQ_ADDR, 8'h01);
        rd_chk("status", crch_pkg::STATUS_ADDR, 32'h6);
        chk("refused", 32'h1, {31'h0, refused});
        wr(cv(8'd20), 8'h35);
        rd_chk("bit weights", cv(8'd20), 32'h35);
        wr(crch_pkg::STATUS_ADDR, 8'h04);
        rd_chk("status cleared", crch_pkg::STATUS_ADDR, 32'h2);
        wr(cv(8'd150), 8'h00);
        wr(crch_pkg::CMD_ADDR, crch_pkg::RESET_CMD_REPEAT);
        wait_idle();
        rd_chk("repeat top", cv(8'd150), 32'hFF);
        rd_chk("repeat set", crch_pkg::LAST_SET_ADDR, 32'h5);
        $display("lock and repeat test done");
        wr(crch_pkg::CTRL_ADDR, 8'h01);
        wr(12'h648, 8'h42);
        wr(cv(8'd8), 8'h03);
        wait_idle();
        rd_chk("sound backlash", cv(8'd146), 32'h42);
        rd_chk("sound table", 12'h648, 32'h42);
        wr(cv(8'd8), crch_pkg::RESET_CMD_FACTORY);
        wait_idle();
        rd_chk("factory backlash", cv(8'd146), 32'h0);
        wr(crch_pkg::FW_REQ_ADDR, 8'h01);
        @(negedge sys_clk_i);
        chk("not refused", 32'h0, {31'h0, refused});
        rd_chk("status sound", crch_pkg::STATUS_ADDR, 32'h8);
        access(1'b0, 12'hA00, 8'h00, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("sound and factory test done");
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        wr(cv(8'd146), 8'h11);
        wr(crch_pkg::CMD_ADDR, crch_pkg::RESET_CMD_REPEAT);
        wait_idle();
        rd_chk("repeat no set", cv(8'd146), 32'h0);
        rd_chk("set cleared", crch_pkg::LAST_SET_ADDR, 32'h0);
        $display("reset and repeat test done");
        print_verdict();
    end
endmodule
`default_nettype wire
